//--- core/mls_pkg.sv
package mls_pkg;

	localparam int unsigned   MLS_ADDR_W       = 4;
	localparam int unsigned   MLS_DATA_W       = 8;
	localparam int unsigned   MLS_LINES        = 4;

	// register offsets on the plain register port
	localparam logic [3:0]    MLS_OFS_STATUS   = 4'h0;
	localparam logic [3:0]    MLS_OFS_IER      = 4'h1;
	localparam logic [3:0]    MLS_OFS_MCR      = 4'h2;
	localparam logic [3:0]    MLS_OFS_EVT      = 4'h3;
	localparam logic [3:0]    MLS_OFS_EVT_EN   = 4'h4;
	localparam logic [3:0]    MLS_OFS_EVT_CLR  = 4'h5;

	// line index inside four-bit groups
	localparam int unsigned   MLS_CTS          = 0;
	localparam int unsigned   MLS_DSR          = 1;
	localparam int unsigned   MLS_RING         = 2;
	localparam int unsigned   MLS_CD           = 3;

	localparam int unsigned   MLS_IER_MODEM    = 3;
	localparam int unsigned   MLS_MCR_LOOP     = 4;

	localparam logic [7:0]    MLS_IER_MASK     = 8'h0F;
	localparam logic [7:0]    MLS_MCR_MASK     = 8'h1F;
	localparam logic [7:0]    MLS_RST_BYTE     = 8'h00;
	localparam logic [3:0]    MLS_RST_NIB      = 4'h0;
	localparam logic [3:0]    MLS_PIN_IDLE     = 4'hF;

	// sticky event bits of the block-level interrupt register
	localparam int unsigned   MLS_EV_CHANGE    = 0;
	localparam int unsigned   MLS_EV_RING      = 1;
	localparam int unsigned   MLS_EV_W         = 2;
	localparam logic [1:0]    MLS_EV_RST       = 2'h0;

endpackage : mls_pkg

//--- core/mls_sync_if.sv
`timescale 1ns/100ps
`default_nettype none

interface mls_sync_if;
	logic [3:0] raw;
	logic [3:0] level;
	logic [3:0] settled;

	modport owner
	(
		output raw,
		input  level,
		input  settled
	);

	modport sync
	(
		input  raw,
		output level,
		output settled
	);
endinterface : mls_sync_if

`default_nettype wire

//--- core/mls_sync.sv
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser; a level counts only when stages two and three agree
module mls_sync
(
	input  wire logic     clk_sys,
	input  wire logic     sys_rst,
	mls_sync_if.sync      lines
);

	typedef struct packed
	{
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] level;
	} mls_sync_state_t;

	mls_sync_state_t st;
	mls_sync_state_t next_st;

	always_comb
	begin
		next_st    = st;
		next_st.s1 = lines.raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < 4; i++)
		begin
			if (st.s2[i] == st.s3[i])
			begin
				next_st.level[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			st <= '{s1: mls_pkg::MLS_PIN_IDLE, s2: mls_pkg::MLS_PIN_IDLE,
				s3: mls_pkg::MLS_PIN_IDLE, level: mls_pkg::MLS_PIN_IDLE};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign lines.level   = st.level;
	assign lines.settled = st.level;

endmodule : mls_sync

`default_nettype wire

//--- core/mls_tracker.sv
`timescale 1ns/100ps
`default_nettype none

module mls_tracker
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       cts_n,
	input  wire logic       dsr_n,
	input  wire logic       ring_n,
	input  wire logic       carrier_detect_input_n,
	output logic            modem_irq,
	output logic            irq
);

	typedef struct packed
	{
		logic [3:0] flags;
		logic [3:0] prev_line;
		logic       prev_valid;
		logic [7:0] ier;
		logic [7:0] mcr;
		logic [1:0] evt;
		logic [1:0] evt_en;
		logic [7:0] rdata;
	} mls_state_t;

	mls_state_t st;
	mls_state_t next_st;

	mls_sync_if pins ();

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction : hit

	// the pins are active low; line_on is high while the line is asserted
	assign pins.raw = {carrier_detect_input_n, ring_n, dsr_n, cts_n};

	mls_sync u_sync
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.lines   (pins.sync)
	);

	logic [3:0] line_on;
	logic [3:0] change;
	logic [7:0] status;
	logic       loop_mode;
	logic       modem_req;

	always_comb
	begin
		loop_mode = st.mcr[mls_pkg::MLS_MCR_LOOP];
		// in loopback the pins are ignored and control bits drive the lines
		if (loop_mode)
		begin
			line_on = st.mcr[3:0];
		end
		else
		begin
			line_on = ~pins.settled;
		end
		change = '0;
		if (st.prev_valid)
		begin
			change[mls_pkg::MLS_CTS]  = line_on[mls_pkg::MLS_CTS] ^
				st.prev_line[mls_pkg::MLS_CTS];
			change[mls_pkg::MLS_DSR]  = line_on[mls_pkg::MLS_DSR] ^
				st.prev_line[mls_pkg::MLS_DSR];
			change[mls_pkg::MLS_RING] = st.prev_line[mls_pkg::MLS_RING] &
				~line_on[mls_pkg::MLS_RING];
			change[mls_pkg::MLS_CD]   = line_on[mls_pkg::MLS_CD] ^
				st.prev_line[mls_pkg::MLS_CD];
		end
		status    = {line_on, st.flags};
		modem_req = |st.flags;
	end

	always_comb
	begin
		next_st            = st;
		next_st.prev_line  = line_on;
		next_st.prev_valid = 1'b1;
		next_st.rdata      = mls_pkg::MLS_RST_BYTE;

		// read clear happens first so a same-cycle change still lands
		if (reg_rd && hit(reg_addr, mls_pkg::MLS_OFS_STATUS))
		begin
			next_st.flags = mls_pkg::MLS_RST_NIB;
		end
		if (reg_wr && hit(reg_addr, mls_pkg::MLS_OFS_STATUS))
		begin
			next_st.flags = reg_wdata[3:0];
		end
		next_st.flags = next_st.flags | change;

		if (reg_wr)
		begin
			case (reg_addr)
				mls_pkg::MLS_OFS_IER:
				begin
					next_st.ier = reg_wdata & mls_pkg::MLS_IER_MASK;
				end
				mls_pkg::MLS_OFS_MCR:
				begin
					next_st.mcr = reg_wdata & mls_pkg::MLS_MCR_MASK;
				end
				mls_pkg::MLS_OFS_EVT_EN:
				begin
					next_st.evt_en = reg_wdata[1:0];
				end
				mls_pkg::MLS_OFS_EVT_CLR:
				begin
					next_st.evt = st.evt & ~reg_wdata[1:0];
				end
				default:
				begin
				end
			endcase
		end
		// sticky events; a set in the clear cycle wins
		if (|change)
		begin
			next_st.evt[mls_pkg::MLS_EV_CHANGE] = 1'b1;
		end
		if (change[mls_pkg::MLS_RING])
		begin
			next_st.evt[mls_pkg::MLS_EV_RING] = 1'b1;
		end

		if (reg_rd)
		begin
			case (reg_addr)
				mls_pkg::MLS_OFS_STATUS:
				begin
					next_st.rdata = status;
				end
				mls_pkg::MLS_OFS_IER:
				begin
					next_st.rdata = st.ier;
				end
				mls_pkg::MLS_OFS_MCR:
				begin
					next_st.rdata = st.mcr;
				end
				mls_pkg::MLS_OFS_EVT:
				begin
					next_st.rdata = {6'h00, st.evt};
				end
				mls_pkg::MLS_OFS_EVT_EN:
				begin
					next_st.rdata = {6'h00, st.evt_en};
				end
				default:
				begin
					next_st.rdata = mls_pkg::MLS_RST_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			st.flags      <= mls_pkg::MLS_RST_NIB;
			st.prev_line  <= mls_pkg::MLS_RST_NIB;
			st.prev_valid <= 1'b0;
			st.ier        <= mls_pkg::MLS_RST_BYTE;
			st.mcr        <= mls_pkg::MLS_RST_BYTE;
			st.evt        <= mls_pkg::MLS_EV_RST;
			st.evt_en     <= mls_pkg::MLS_EV_RST;
			st.rdata      <= mls_pkg::MLS_RST_BYTE;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign modem_irq = modem_req & st.ier[mls_pkg::MLS_IER_MODEM];
	// block-level line, separate from the modem request path
	assign irq       = |(st.evt & st.evt_en);

endmodule : mls_tracker

`default_nettype wire

//--- sim/mls_tracker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module mls_tracker_assertions
(
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       cts_n,
	input wire logic       dsr_n,
	input wire logic       ring_n,
	input wire logic       carrier_detect_input_n,
	input wire logic       modem_irq,
	input wire logic       irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire logic [3:0] pins = {carrier_detect_input_n, ring_n, dsr_n, cts_n};
	logic            ien;
	// shadow of the modem enable bit, so gating is checked without peeking inside
	always_ff @(posedge clk_sys)
		if (sys_rst)
			ien <= 1'b0;
		else if (reg_wr && reg_addr == mls_pkg::MLS_OFS_IER)
			ien <= reg_wdata[mls_pkg::MLS_IER_MODEM];
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_irq_gated: assert property (!ien |-> !modem_irq)
		else $error("modem irq while disabled");
	a_status_wr: assert property (reg_wr && reg_addr == mls_pkg::MLS_OFS_STATUS &&
		|reg_wdata[3:0] |=> modem_irq == ien) else $error("status write no irq");
	a_read_clear: assert property ($stable(pins)[*6] ##0
		(reg_rd && reg_addr == mls_pkg::MLS_OFS_STATUS) |=> !modem_irq)
		else $error("status read did not clear");
	a_ring_edge: assert property ($rose(ring_n) && ien |-> ##[1:6] modem_irq)
		else $error("ring trailing edge missed");
	a_line_change: assert property ($changed({pins[3], pins[1:0]}) && ien
		|-> ##[1:6] modem_irq) else $error("line change missed");
	a_irq_mask: assert property (reg_wr && reg_addr == mls_pkg::MLS_OFS_EVT_EN
		&& reg_wdata[1:0] == 2'h0 |=> !irq) else $error("masked irq high");
	a_evt_clear: assert property ($stable(pins)[*6] ##0 (reg_wr && reg_wdata[1:0] == 2'h3
		&& reg_addr == mls_pkg::MLS_OFS_EVT_CLR) |=> !irq) else $error("irq not cleared");
endmodule : mls_tracker_assertions
bind mls_tracker mls_tracker_assertions u_mls_tracker_assertions (.*);
`default_nettype wire

//--- sim/mls_modem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mls_modem_model
(
	input  wire logic       clk_sys,
	input  wire logic [3:0] line_on,
	output logic            cts_n,
	output logic            dsr_n,
	output logic            ring_n,
	output logic            carrier_detect_input_n
);
	// pins are active low, idle off
	initial {carrier_detect_input_n, ring_n, dsr_n, cts_n} = 4'hF;
	always @(posedge clk_sys)
		{carrier_detect_input_n, ring_n, dsr_n, cts_n} <= ~line_on;
endmodule : mls_modem_model
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       clk_sys = 1'b0;
	logic       sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] rv;
	logic [3:0] line_on = 4'h0;
	logic       cts_n, dsr_n, ring_n, cd_n, modem_irq, irq;
	int         n_fail = 0;
	int         n_checks = 0;
	initial forever #12.5 clk_sys = ~clk_sys;
	mls_modem_model u_mls_modem_model (.clk_sys(clk_sys), .line_on(line_on), .cts_n(cts_n),
		.dsr_n(dsr_n), .ring_n(ring_n), .carrier_detect_input_n(cd_n));
	mls_tracker u_mls_tracker (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cts_n(cts_n), .dsr_n(dsr_n), .ring_n(ring_n), .carrier_detect_input_n(cd_n),
		.modem_irq(modem_irq), .irq(irq));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd
	// pins pass three sync stages plus detect, so eight cycles always settle
	task automatic wt;
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : wt
	task automatic t_lines;
		wr(mls_pkg::MLS_OFS_IER, 8'h08);
		wr(mls_pkg::MLS_OFS_EVT_EN, 8'h03);
		for (int i = 0; i < 4; i++)
		begin
			line_on = 4'h1 << i;
			wt;
			chk(modem_irq, i != 2);
			rd(mls_pkg::MLS_OFS_STATUS);
			chk(rv, {line_on, (i == 2) ? 4'h0 : line_on});
			rd(mls_pkg::MLS_OFS_STATUS);
			chk(rv, {line_on, 4'h0});
			chk(modem_irq, 1'b0);
			line_on = 4'h0;
			wt;
			rd(mls_pkg::MLS_OFS_STATUS);
			chk(rv, {4'h0, 4'h1 << i});
		end
		chk(irq, 1'b1);
		wr(mls_pkg::MLS_OFS_EVT_EN, 8'h00);
		chk(irq, 1'b0);
		wr(mls_pkg::MLS_OFS_EVT_EN, 8'h03);
		chk(irq, 1'b1);
		wr(mls_pkg::MLS_OFS_EVT_CLR, 8'h03);
		rd(mls_pkg::MLS_OFS_EVT);
		chk(irq, 1'b0);
		chk(rv, 8'h00);
		$display("lines test done");
	endtask : t_lines
	task automatic t_swr;
		wr(mls_pkg::MLS_OFS_IER, 8'h00);
		wr(mls_pkg::MLS_OFS_STATUS, 8'hFA);
		chk(modem_irq, 1'b0);
		rd(mls_pkg::MLS_OFS_STATUS);
		chk(rv, 8'h0A);
		wr(mls_pkg::MLS_OFS_STATUS, 8'h05);
		wr(mls_pkg::MLS_OFS_IER, 8'h08);
		chk(modem_irq, 1'b1);
		rd(4'hF);
		chk(rv, 8'h00);
		$display("status write test done");
	endtask : t_swr
	task automatic t_loop;
		wr(mls_pkg::MLS_OFS_IER, 8'h00);
		wr(mls_pkg::MLS_OFS_MCR, 8'h15);
		line_on = 4'hF;
		wt;
		rd(mls_pkg::MLS_OFS_STATUS);
		chk(rv[7:4], 8'h05);
		line_on = 4'h0;
		wr(mls_pkg::MLS_OFS_MCR, 8'h00);
		wt;
		rd(mls_pkg::MLS_OFS_STATUS);
		// leaving loopback shows the stale pins all on (DSR and CD jump on), then every line goes off, so all four flags set
		chk(rv, 8'h0F);
		rd(mls_pkg::MLS_OFS_STATUS);
		chk(rv, 8'h00);
		$display("loopback test done");
	endtask : t_loop
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(mls_pkg::MLS_OFS_STATUS);
		chk(rv, 8'h00);
		t_lines;
		t_swr;
		t_loop;
		end_of_test;
	end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		end_of_test;
	end
endmodule : tb
`default_nettype wire
